// file: pbcc_ahb_slave.v
// AHB-Lite slave front end: zero-wait writes, one-wait reads from a registered read bus
`timescale 1ns/1ps
`include "pbcc_consts.vh"

module pbcc_ahb_slave (
  input wire clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output wire wr_pulse,
  output wire [31:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [31:0] rd_addr,
  input wire [31:0] rd_data
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WR = 3'h2;
  localparam [2:0] ST_RD = 3'h4;

  reg [2:0] state_q;
  reg [31:0] addr_q;
  wire accept;

  // Only whole-word singles are expected; hsize is not checked
  assign accept = hsel & htrans[1] & hready;
  assign wr_pulse = (state_q == ST_WR);
  assign wr_addr = addr_q;
  assign wr_data = hwdata;
  assign rd_addr = addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read waits one cycle so a write in the preceding data phase is seen
  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      addr_q <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      case (state_q)
        ST_IDLE, ST_WR: begin
          if (accept) begin
            addr_q <= haddr;
            if (hwrite) begin
              state_q <= ST_WR;
            end else begin
              state_q <= ST_RD;
              hreadyout <= 1'b0;
            end
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_RD: begin
          hrdata <= rd_data;
          hreadyout <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

endmodule

// file: pbcc_channel.v
// Port bypass control channel four: register, pin takeover, auto-clear and interrupt logic
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pbcc_consts.vh"

module pbcc_channel (
  input wire clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire port4_bit1_pin_in,
  output wire port4_bit1_pin_out,
  output wire port4_bit1_pin_oe,
  output wire port4_bit1_pull_en,
  input wire port4_bit0_pin_in,
  output wire port4_bit0_pin_out,
  output wire port4_bit0_pin_oe,
  output wire port4_bit0_pull_en,
  input wire gp_bit1_out,
  input wire gp_bit1_oe,
  input wire [1:0] gp_bit1_bypass_sel,
  input wire gp_bit1_bypass_src,
  input wire gp_bit0_out,
  input wire gp_bit0_oe,
  input wire [1:0] gp_bit0_bypass_sel,
  input wire gp_bit0_bypass_src,
  output reg irq
);

  function is_addr;
    input [31:0] addr;
    input [31:0] target;
    begin
      is_addr = (addr == target);
    end
  endfunction

  wire wr_pulse;
  wire [31:0] wr_addr;
  wire [31:0] wr_data;
  wire [31:0] rd_addr;
  reg [31:0] rd_data;

  wire [1:0] pin_in;
  wire [1:0] pin_level;
  wire [1:0] gp_out;
  wire [1:0] gp_oe;
  wire [1:0] bsel_active;
  wire [1:0] bsrc;
  wire [1:0] pin_out_q;
  wire [1:0] pin_oe_q;
  wire [1:0] pull_en_q;

  reg enable_q;
  reg irq_en_q;
  reg force_bypass_q;
  reg force_bypass_d;
  reg det_prev_q;
  reg [`PBCC_IRQ_WIDTH-1:0] irq_status_q;
  reg [`PBCC_IRQ_WIDTH-1:0] irq_status_d;
  reg [`PBCC_IRQ_WIDTH-1:0] irq_mask_q;
  reg [`PBCC_IRQ_WIDTH-1:0] irq_event;
  reg [7:0] irq_source_q;
  wire signal_detected;
  wire wr_chan;
  wire wr_status;
  wire wr_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  pbcc_ahb_slave u_bus (
    .clk(clk),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  assign wr_chan = wr_pulse & is_addr(wr_addr, `PBCC_ADDR_CHAN4);
  assign wr_status = wr_pulse & is_addr(wr_addr, `PBCC_ADDR_IRQ_STATUS);
  assign wr_mask = wr_pulse & is_addr(wr_addr, `PBCC_ADDR_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Pin input conditioning; index 1 is force-bypass, index 0 is signal detect

  assign pin_in = {port4_bit1_pin_in, port4_bit0_pin_in};
  assign gp_out = {gp_bit1_out, gp_bit0_out};
  assign gp_oe = {gp_bit1_oe, gp_bit0_oe};
  assign bsel_active = {|gp_bit1_bypass_sel, |gp_bit0_bypass_sel};
  assign bsrc = {gp_bit1_bypass_src, gp_bit0_bypass_src};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      pbcc_sync_filter u_filt (
        .clk(clk),
        .srst(srst),
        .pin_in(pin_in[gi]),
        .level_q(pin_level[gi])
      );
    end
  endgenerate

  // High means a high-speed signal is present
  assign signal_detected = pin_level[0];

  ////////////////////////////////////////////////////////////////////////////
  // Channel register

  // Hardware clear beats a host write of one: host must keep signal detect high to set it
  always @* begin
    force_bypass_d = force_bypass_q;
    if (wr_chan) begin
      force_bypass_d = wr_data[`PBCC_BIT_FORCE_BYPASS];
    end
    if (!signal_detected) begin
      force_bypass_d = 1'b0;
    end
  end

  // Signal-detected and reserved bits hold no storage, so writes to them vanish
  always @(posedge clk) begin
    if (srst) begin
      enable_q <= `PBCC_RST_ENABLE;
      irq_en_q <= `PBCC_RST_IRQ_EN;
      force_bypass_q <= `PBCC_RST_FORCE_BYPASS;
    end else begin
      if (wr_chan) begin
        enable_q <= wr_data[`PBCC_BIT_ENABLE];
        irq_en_q <= wr_data[`PBCC_BIT_IRQ_EN];
      end
      force_bypass_q <= force_bypass_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; bypass select keeps priority over the channel takeover

  // Drive choice as {out, oe, pull}
  function [2:0] pin_drive;
    input bsel;
    input bsrc_v;
    input chan_on;
    input is_ctl_pin;
    input ctl_val;
    input gout;
    input goe;
    begin
      if (bsel) begin
        pin_drive = {bsrc_v, 1'b1, 1'b0};
      end else if (chan_on) begin
        if (is_ctl_pin) begin
          pin_drive = {ctl_val, 1'b1, 1'b0};
        end else begin
          pin_drive = {1'b0, 1'b0, 1'b1};
        end
      end else begin
        pin_drive = {gout, goe, ~goe};
      end
    end
  endfunction

  // One flop group per pin keeps each output with a single driver
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_drive
      reg [2:0] drv_q;
      always @(posedge clk) begin
        if (srst) begin
          drv_q <= 3'h1;
        end else begin
          drv_q <= pin_drive(bsel_active[gi], bsrc[gi], enable_q, gi == 1, force_bypass_d, gp_out[gi], gp_oe[gi]);
        end
      end
      assign pin_out_q[gi] = drv_q[2];
      assign pin_oe_q[gi] = drv_q[1];
      assign pull_en_q[gi] = drv_q[0];
    end
  endgenerate

  assign port4_bit1_pin_out = pin_out_q[1];
  assign port4_bit1_pin_oe = pin_oe_q[1];
  assign port4_bit1_pull_en = pull_en_q[1];
  assign port4_bit0_pin_out = pin_out_q[0];
  assign port4_bit0_pin_oe = pin_oe_q[0];
  assign port4_bit0_pull_en = pull_en_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: events are sticky, cleared by writing one, set wins over clear

  always @* begin
    irq_event = {`PBCC_IRQ_WIDTH{1'b0}};
    irq_event[`PBCC_IRQ_BIT_DET_EDGE] = enable_q & irq_en_q & (signal_detected != det_prev_q);
    irq_event[`PBCC_IRQ_BIT_BYP_CLEAR] = enable_q & force_bypass_q & ~signal_detected;
    irq_status_d = irq_status_q;
    if (wr_status) begin
      irq_status_d = irq_status_q & ~wr_data[`PBCC_IRQ_WIDTH-1:0];
    end
    irq_status_d = irq_status_d | irq_event;
  end

  always @(posedge clk) begin
    if (srst) begin
      det_prev_q <= `PBCC_RST_PIN_LEVEL;
      irq_status_q <= {`PBCC_IRQ_WIDTH{1'b0}};
      irq_mask_q <= `PBCC_RST_IRQ_MASK;
      irq_source_q <= 8'h00;
      irq <= 1'b0;
    end else begin
      det_prev_q <= signal_detected;
      irq_status_q <= irq_status_d;
      if (wr_mask) begin
        irq_mask_q <= wr_data[`PBCC_IRQ_WIDTH-1:0];
      end
      if (irq_event[`PBCC_IRQ_BIT_DET_EDGE]) begin
        irq_source_q <= `PBCC_SOURCE_VALUE;
      end
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero

  always @* begin
    rd_data = 32'h00000000;
    if (is_addr(rd_addr, `PBCC_ADDR_CHAN4)) begin
      rd_data[`PBCC_BIT_ENABLE] = enable_q;
      rd_data[`PBCC_BIT_IRQ_EN] = irq_en_q;
      rd_data[`PBCC_BIT_FORCE_BYPASS] = pin_level[1];
      rd_data[`PBCC_BIT_SIGNAL_DET] = pin_level[0];
    end else if (is_addr(rd_addr, `PBCC_ADDR_IRQ_STATUS)) begin
      rd_data[`PBCC_IRQ_WIDTH-1:0] = irq_status_q;
    end else if (is_addr(rd_addr, `PBCC_ADDR_IRQ_MASK)) begin
      rd_data[`PBCC_IRQ_WIDTH-1:0] = irq_mask_q;
    end else if (is_addr(rd_addr, `PBCC_ADDR_IRQ_SOURCE)) begin
      rd_data[7:0] = irq_source_q;
    end
  end

endmodule

// file: pbcc_channel_assertions.sv
// Port-level checks for the port bypass control channel
`timescale 1ns/1ps
module pbcc_channel_assertions (
  input wire clk,
  input wire srst,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire port4_bit1_pin_out,
  input wire port4_bit1_pin_oe,
  input wire port4_bit1_pull_en,
  input wire port4_bit0_pin_in,
  input wire port4_bit0_pin_out,
  input wire port4_bit0_pin_oe,
  input wire port4_bit0_pull_en,
  input wire gp_bit1_oe,
  input wire [1:0] gp_bit1_bypass_sel,
  input wire gp_bit1_bypass_src,
  input wire [1:0] gp_bit0_bypass_sel,
  input wire gp_bit0_bypass_src,
  input wire irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic [6:0] low_cnt_q;
  wire taken = hsel && htrans[1] && hready;
  ////////////////////////////////////////////////////////////////////////////
  // Saturates so a long loss never wraps back
  always_ff @(posedge clk) begin
    if (srst || port4_bit0_pin_in)
      low_cnt_q <= 7'h00;
    else if (low_cnt_q != 7'h7F)
      low_cnt_q <= low_cnt_q + 7'h01;
  end
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (taken && !hwrite |=> s_rd_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
  a_reset_pins: assert property ($fell(srst) |-> !port4_bit1_pin_oe && !port4_bit0_pin_oe &&
    port4_bit1_pull_en && port4_bit0_pull_en && !irq)
    else $error("pins not inputs after reset");
  a_bypass_wins: assert property (gp_bit1_bypass_sel != 2'h0 |=> port4_bit1_pin_oe &&
    port4_bit1_pin_out == $past(gp_bit1_bypass_src))
    else $error("bypass select ignored on bit1");
  a_bypass_bit0: assert property (gp_bit0_bypass_sel != 2'h0 |=> port4_bit0_pin_oe &&
    port4_bit0_pin_out == $past(gp_bit0_bypass_src))
    else $error("bypass select ignored on bit0");
  a_detect_input: assert property (port4_bit1_pin_oe && !$past(gp_bit1_oe) &&
    $past(gp_bit1_bypass_sel) == 2'h0 && $past(gp_bit0_bypass_sel) == 2'h0
    |-> !port4_bit0_pin_oe && port4_bit0_pull_en)
    else $error("detect pin not an input");
  a_loss_clear: assert property (low_cnt_q == 7'h50 && port4_bit1_pin_oe && !gp_bit1_oe &&
    gp_bit1_bypass_sel == 2'h0 |-> !port4_bit1_pin_out)
    else $error("bypass not forced after loss");
endmodule

// file: pbcc_consts.vh
// Constants for the port bypass control channel: addresses, bit positions, reset values, timing
//
// Behaviour
// - While enabled, the channel owns both pins: bit1 drives force-bypass, bit0 senses signal detect.
// - Enabling overrides general pin settings, except the two bypass select bits per pin.
// - With enable low, the other register bits do not affect the two pins.
// - Force-bypass bit one drives the pin high: external circuit in normal mode.
// - Force-bypass bit zero drives the pin low: external circuit bypasses the port.
// - While enabled, the force-bypass pin is a push-pull output following its bit.
// - Filtered signal-detect low clears force-bypass; output follows within 400 ns.
// - After reset every pin is an input with its weak pull-up on.
// - Reads of the pin bits return the synchronised, filtered pin levels.
// - While enabled, bit0 is read-only and shows the signal-detect pin.
// - Signal-detected bit is one with a high-speed signal present, zero otherwise.
// - The channel register sits at byte address 24h and drives its own pin pair.
// - With enable and irq enable both set, any signal-detect transition raises the interrupt and logs the address.
`ifndef PBCC_CONSTS_VH
`define PBCC_CONSTS_VH

`define PBCC_ADDR_CHAN4 32'h00000024
`define PBCC_ADDR_IRQ_STATUS 32'h00000028
`define PBCC_ADDR_IRQ_MASK 32'h0000002C
`define PBCC_ADDR_IRQ_SOURCE 32'h00000030

`define PBCC_BIT_ENABLE 7
`define PBCC_BIT_IRQ_EN 6
`define PBCC_BIT_FORCE_BYPASS 1
`define PBCC_BIT_SIGNAL_DET 0

`define PBCC_IRQ_BIT_DET_EDGE 0
`define PBCC_IRQ_BIT_BYP_CLEAR 1
`define PBCC_IRQ_WIDTH 2

`define PBCC_RST_ENABLE 1'b0
`define PBCC_RST_IRQ_EN 1'b0
`define PBCC_RST_FORCE_BYPASS 1'b1
`define PBCC_RST_IRQ_MASK 2'h1
`define PBCC_RST_PIN_LEVEL 1'b1
`define PBCC_SOURCE_VALUE 8'h24

`define PBCC_CLK_MHZ 200
`define PBCC_MAX_LAT_NS 400
`define PBCC_FILTER_NS 200
`define PBCC_FILTER_CYC ((`PBCC_FILTER_NS * `PBCC_CLK_MHZ) / 1000)
`define PBCC_FILTER_CW 6

`endif

// file: pbcc_sd_unit.sv
// Behavioural signal detect and bypass unit beyond the pins
`timescale 1ns/1ps
module pbcc_sd_unit (
  input wire clk,
  input wire signal_on,
  input wire bypass_ctl_level,
  output logic det_out,
  output logic bypassed
);
  always_ff @(posedge clk) begin
    det_out <= signal_on;
    bypassed <= !bypass_ctl_level;
  end
endmodule

// file: pbcc_sync_filter.v
// Two-stage input synchroniser followed by a stability filter
`timescale 1ns/1ps
`include "pbcc_consts.vh"

module pbcc_sync_filter (
  input wire clk,
  input wire srst,
  input wire pin_in,
  output reg level_q
);

  localparam integer FILT_LAST_INT = `PBCC_FILTER_CYC - 1;
  localparam [`PBCC_FILTER_CW-1:0] FILT_LAST = FILT_LAST_INT[`PBCC_FILTER_CW-1:0];

  reg meta_q;
  reg sync_q;
  reg [`PBCC_FILTER_CW-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up default so a floating pin reads high from reset
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= `PBCC_RST_PIN_LEVEL;
      sync_q <= `PBCC_RST_PIN_LEVEL;
      level_q <= `PBCC_RST_PIN_LEVEL;
      cnt_q <= {`PBCC_FILTER_CW{1'b0}};
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      if (sync_q == level_q) begin
        cnt_q <= {`PBCC_FILTER_CW{1'b0}};
      end else if (cnt_q == FILT_LAST) begin
        level_q <= sync_q;
        cnt_q <= {`PBCC_FILTER_CW{1'b0}};
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

// file: port_bypass_control_channel_tb.sv
// Self-checking bench for the port bypass control channel
`timescale 1ns/1ps
module port_bypass_control_channel_tb;
  logic clk, srst, hsel, hwrite, pd1, sig, g1o, g1e, s1, g0o, g0e, s0;
  logic [1:0] htrans, sel1, sel0;
  logic [31:0] haddr, hwdata, rd;
  wire hreadyout, hresp, o1, e1, p1, o0, e0, p0, irq, det, byp;
  wire [31:0] hrdata;
  wire hready = hreadyout;
  // External pull-down beats the weak pull-up
  wire lvl1 = e1 ? o1 : (pd1 ? 1'b0 : p1);
  wire lvl0 = e0 ? o0 : det;
  int error_cnt, samples_checked, cyc;
  pbcc_channel pbcc_channel_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port4_bit1_pin_in(lvl1), .port4_bit1_pin_out(o1), .port4_bit1_pin_oe(e1),
    .port4_bit1_pull_en(p1), .port4_bit0_pin_in(lvl0), .port4_bit0_pin_out(o0), .port4_bit0_pin_oe(e0),
    .port4_bit0_pull_en(p0), .gp_bit1_out(g1o), .gp_bit1_oe(g1e), .gp_bit1_bypass_sel(sel1),
    .gp_bit1_bypass_src(s1), .gp_bit0_out(g0o), .gp_bit0_oe(g0e), .gp_bit0_bypass_sel(sel0),
    .gp_bit0_bypass_src(s0), .irq(irq));
  pbcc_sd_unit pbcc_sd_unit_inst (.clk(clk), .signal_on(sig), .bypass_ctl_level(lvl1), .det_out(det),
    .bypassed(byp));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({e1, e0, p1, p0, irq}, 32'h6);
    rdc(32'h24, 32'h1);
    rdc(32'h2C, 32'h1);
    rdc(32'h40, 32'h0);
  endtask
  task automatic t_enable();
    bus(1'b1, 32'h24, 32'h80);
    wt(3);
    chk({e1, o1, byp, e0}, 32'hA);
    wt(45);
    rdc(32'h24, 32'h81);
    bus(1'b1, 32'h24, 32'hBE);
    wt(45);
    chk({o1, byp}, 32'h2);
    rdc(32'h24, 32'h83);
  endtask
  task automatic t_loss();
    int n;
    bus(1'b1, 32'h2C, 32'h3);
    bus(1'b1, 32'h24, 32'hC2);
    sig <= 1'b0;
    for (n = 0; n < 80 && o1 !== 1'b0; n++)
      @(posedge clk);
    chk(o1, 32'h0);
    wt(45);
    rdc(32'h24, 32'hC0);
    chk(irq, 32'h1);
    rdc(32'h28, 32'h3);
    rdc(32'h30, 32'h24);
    bus(1'b1, 32'h28, 32'h3);
    wt(2);
    chk(irq, 32'h0);
    bus(1'b1, 32'h2C, 32'h0);
    sig <= 1'b1;
    wt(50);
    rdc(32'h28, 32'h1);
    chk(irq, 32'h0);
    bus(1'b1, 32'h2C, 32'h1);
    wt(2);
    chk(irq, 32'h1);
    bus(1'b1, 32'h28, 32'h1);
    wt(2);
    chk(irq, 32'h0);
  endtask
  task automatic t_disabled();
    bus(1'b1, 32'h24, 32'h02);
    g1e <= 1'b1;
    g0e <= 1'b1;
    g0o <= 1'b1;
    wt(3);
    chk({e1, o1, e0, o0}, 32'hB);
    sel1 <= 2'h1;
    sel0 <= 2'h2;
    s0 <= 1'b1;
    bus(1'b1, 32'h24, 32'h82);
    wt(3);
    chk({e1, o1, e0, o0}, 32'hB);
    sel0 <= 2'h0;
    wt(3);
    chk({e0, p0}, 32'h1);
    sel1 <= 2'h0;
    g1e <= 1'b0;
    wt(3);
    chk({e1, o1}, 32'h3);
  endtask
  initial begin
    {srst, pd1, sig} = 3'h7;
    {hsel, hwrite, g1o, g1e, s1, g0o, g0e, s0} = 8'h0;
    {htrans, sel1, sel0} = 6'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    wt(6);
    srst <= 1'b0;
    wt(50);
    t_reset();
    t_enable();
    t_loss();
    t_disabled();
    complete_run();
  end
endmodule

bind pbcc_channel pbcc_channel_assertions pbcc_channel_assertions_inst (.clk(clk), .srst(srst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .port4_bit1_pin_out(port4_bit1_pin_out), .port4_bit1_pin_oe(port4_bit1_pin_oe),
  .port4_bit1_pull_en(port4_bit1_pull_en), .port4_bit0_pin_in(port4_bit0_pin_in),
  .port4_bit0_pin_out(port4_bit0_pin_out), .port4_bit0_pin_oe(port4_bit0_pin_oe),
  .port4_bit0_pull_en(port4_bit0_pull_en), .gp_bit1_oe(gp_bit1_oe), .gp_bit1_bypass_sel(gp_bit1_bypass_sel),
  .gp_bit1_bypass_src(gp_bit1_bypass_src), .gp_bit0_bypass_sel(gp_bit0_bypass_sel),
  .gp_bit0_bypass_src(gp_bit0_bypass_src), .irq(irq));
